// [verilog/dpm_pkg.sv]
// Purpose: Constants for the external bus and DMA pin multiplexer
// Assumes: AHB-Lite register slave, 32-bit words, byte addresses
// Notes: Pin indices select bits of the pin_i, pin_o and pin_oe vectors
package dpm_pkg;

	// Register byte offsets
	localparam logic [7:0] OFS_FUNC = 8'h00;
	localparam logic [7:0] OFS_PA_DATA = 8'h04;
	localparam logic [7:0] OFS_PA_DIR = 8'h08;
	localparam logic [7:0] OFS_PB_DATA = 8'h0c;
	localparam logic [7:0] OFS_PB_DIR = 8'h10;
	localparam logic [7:0] OFS_P8_DATA = 8'h14;
	localparam logic [7:0] OFS_P8_DIR = 8'h18;
	localparam logic [7:0] OFS_P9_DATA = 8'h1c;
	localparam logic [7:0] OFS_P9_DIR = 8'h20;
	localparam logic [7:0] OFS_PIN_LVL = 8'h24;
	localparam logic [7:0] OFS_CORE_STAT = 8'h28;

	// Function enable register fields
	localparam int FB_ACK_EN = 0;
	localparam int FB_END_EN = 1;
	localparam int FB_STOP_EN = 2;
	localparam int FB_FBW_EN = 3;
	localparam int FB_FBR_EN = 4;
	localparam int FB_RDY_EN = 5;
	localparam int FB_GNT_EN = 6;
	localparam int FB_BRQ_EN = 7;
	localparam int FB_WRL_EN = 8;
	localparam int FB_WE_EN = 9;
	localparam int FB_SRAM_MODE = 10;
	localparam int FB_REQ_SRC = 11;
	localparam int FB_REQ_DRIVE = 12;
	localparam int FB_CS_LSB = 16;

	// Reset values
	localparam logic [31:0] FUNC_RST = 32'h0000_0000;
	localparam logic [7:0] PORT_RST = 8'h00;
	localparam logic [31:0] HRDATA_RST = 32'h0000_0000;

	// Ports, as index into the data and direction arrays
	localparam int NPORT = 4;
	localparam logic [1:0] PORT_A = 2'h0;
	localparam logic [1:0] PORT_B = 2'h1;
	localparam logic [1:0] PORT_8 = 2'h2;
	localparam logic [1:0] PORT_9 = 2'h3;

	// Pin indices
	localparam int NPIN = 20;
	localparam int P_REQ = 0;
	localparam int P_ACK = 1;
	localparam int P_EOP = 2;
	localparam int P_FBW = 3;
	localparam int P_FBR = 4;
	localparam int P_CS0 = 5;
	localparam int P_RDY = 13;
	localparam int P_GNT = 14;
	localparam int P_BRQ = 15;
	localparam int P_WRH = 16;
	localparam int P_WRL = 17;
	localparam int P_WE = 18;
	localparam int P_RD = 19;

endpackage

// [verilog/dpm_pin_mux.sv]
// Purpose: Chooses dedicated DMA and bus functions or port bits per pin
// Assumes: One clock; pin inputs are asynchronous and pass two flops
// Notes: Every pin output and enable is a flop, so a mode change is clean
//
// How it works
// - Selected request pin sampled always, drive stopped unless drive bit set
// - Acknowledge pin driven only when enabled
// - Transfer end driven only when enabled
// - Transfer stop accepted only when enabled
// - End/stop pin is port when both off
// - Fly-by write strobe out when enabled
// - Fly-by read strobe out when enabled
// - Disabled fly-by strobe pin returns to port
// - Each chip select has own enable
// - Ready extends cycles only when enabled
// - Grant driven low while bus released
// - Dedicated read strobe output always
// - SRAM mode: first strobe is high mask
// - SRAM mode: second strobe is low mask
// - SRAM mode: separate pin carries write strobe
// - Mask or strobe pin port only when disabled
// - Disabled grant pin becomes port bit
//
// Decided for this implementation: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/100ps

module dpm_pin_mux (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Device pins
	input wire logic [dpm_pkg::NPIN-1:0] pin_i,
	output logic [dpm_pkg::NPIN-1:0] pin_o,
	output logic [dpm_pkg::NPIN-1:0] pin_oe,
	// DMA channel 1 side
	input wire logic dma1_ack_out,
	input wire logic dma1_transfer_end_out,
	input wire logic flyby_write_strobe,
	input wire logic flyby_read_strobe,
	output logic dma1_ext_request_in,
	output logic dma1_transfer_stop_in,
	// Bus controller side
	input wire logic [7:0] chip_select,
	input wire logic read_strobe,
	input wire logic write_strobe_high,
	input wire logic write_strobe_low,
	input wire logic sram_high_byte_mask,
	input wire logic sram_low_byte_mask,
	input wire logic sram_write_strobe,
	input wire logic bus_released,
	output logic ext_ready_in,
	output logic bus_release_request_in
);

	// Register state
	logic [31:0] func_q;
	logic [31:0] func_d;
	logic [7:0] port_data_q [dpm_pkg::NPORT];
	logic [7:0] port_data_d [dpm_pkg::NPORT];
	logic [7:0] port_dir_q [dpm_pkg::NPORT];
	logic [7:0] port_dir_d [dpm_pkg::NPORT];

	// Bus data phase state
	logic wr_pend_q;
	logic [7:0] wr_addr_q;
	logic [31:0] hrdata_q;

	// Pin path
	logic [dpm_pkg::NPIN-1:0] sync1_q;
	logic [dpm_pkg::NPIN-1:0] sync2_q;
	logic [dpm_pkg::NPIN-1:0] pin_o_q;
	logic [dpm_pkg::NPIN-1:0] pin_oe_q;
	logic [dpm_pkg::NPIN-1:0] fn_sel;
	logic [dpm_pkg::NPIN-1:0] fn_o;
	logic [dpm_pkg::NPIN-1:0] fn_oe;
	logic [dpm_pkg::NPIN-1:0] prt_o;
	logic [dpm_pkg::NPIN-1:0] prt_oe;
	logic [dpm_pkg::NPIN-1:0] pin_o_d;
	logic [dpm_pkg::NPIN-1:0] pin_oe_d;

	// Core-facing inputs
	logic req_q;
	logic stop_q;
	logic rdy_q;
	logic brq_q;
	logic req_d;
	logic stop_d;
	logic rdy_d;
	logic brq_d;

	// Named function enables
	wire ack_en = func_q[dpm_pkg::FB_ACK_EN];
	wire end_en = func_q[dpm_pkg::FB_END_EN];
	wire stop_en = func_q[dpm_pkg::FB_STOP_EN];
	wire fbw_en = func_q[dpm_pkg::FB_FBW_EN];
	wire fbr_en = func_q[dpm_pkg::FB_FBR_EN];
	wire rdy_en = func_q[dpm_pkg::FB_RDY_EN];
	wire gnt_en = func_q[dpm_pkg::FB_GNT_EN];
	wire brq_en = func_q[dpm_pkg::FB_BRQ_EN];
	wire wrl_en = func_q[dpm_pkg::FB_WRL_EN];
	wire we_en = func_q[dpm_pkg::FB_WE_EN];
	wire sram_mode = func_q[dpm_pkg::FB_SRAM_MODE];
	wire req_src = func_q[dpm_pkg::FB_REQ_SRC];
	wire req_drive = func_q[dpm_pkg::FB_REQ_DRIVE];
	wire [7:0] cs_en = func_q[dpm_pkg::FB_CS_LSB +: 8];

	// Address phase decode
	wire addr_phase = hsel & htrans[1] & hready;
	wire [7:0] a_addr = haddr[7:0];
	wire a_write = addr_phase & hwrite;
	wire a_read = addr_phase & ~hwrite;

	// Data phase write decode
	wire w_func = wr_pend_q & (wr_addr_q == dpm_pkg::OFS_FUNC);
	wire w_pa_data = wr_pend_q & (wr_addr_q == dpm_pkg::OFS_PA_DATA);
	wire w_pa_dir = wr_pend_q & (wr_addr_q == dpm_pkg::OFS_PA_DIR);
	wire w_pb_data = wr_pend_q & (wr_addr_q == dpm_pkg::OFS_PB_DATA);
	wire w_pb_dir = wr_pend_q & (wr_addr_q == dpm_pkg::OFS_PB_DIR);
	wire w_p8_data = wr_pend_q & (wr_addr_q == dpm_pkg::OFS_P8_DATA);
	wire w_p8_dir = wr_pend_q & (wr_addr_q == dpm_pkg::OFS_P8_DIR);
	wire w_p9_data = wr_pend_q & (wr_addr_q == dpm_pkg::OFS_P9_DATA);
	wire w_p9_dir = wr_pend_q & (wr_addr_q == dpm_pkg::OFS_P9_DIR);
	wire [3:0] w_data = {w_p9_data, w_p8_data, w_pb_data, w_pa_data};
	wire [3:0] w_dir = {w_p9_dir, w_p8_dir, w_pb_dir, w_pa_dir};

	// Next register values; reads use these so a read right after a write sees it
	assign func_d = w_func ? hwdata : func_q;

	genvar gp;
	generate
		for (gp = 0; gp < dpm_pkg::NPORT; gp++) begin : g_port
			assign port_data_d[gp] = w_data[gp] ? hwdata[7:0] : port_data_q[gp];
			assign port_dir_d[gp] = w_dir[gp] ? hwdata[7:0] : port_dir_q[gp];
		end
	endgenerate

	// Status words
	wire [31:0] pin_lvl = {12'h000, sync2_q};
	wire [31:0] core_stat = {28'h0000000, brq_q, rdy_q, stop_q, req_q};

	// Read mux, unmapped offsets read zero
	wire [31:0] rd_val =
		(a_addr == dpm_pkg::OFS_FUNC) ? func_d :
		(a_addr == dpm_pkg::OFS_PA_DATA) ? {24'h000000, port_data_d[dpm_pkg::PORT_A]} :
		(a_addr == dpm_pkg::OFS_PA_DIR) ? {24'h000000, port_dir_d[dpm_pkg::PORT_A]} :
		(a_addr == dpm_pkg::OFS_PB_DATA) ? {24'h000000, port_data_d[dpm_pkg::PORT_B]} :
		(a_addr == dpm_pkg::OFS_PB_DIR) ? {24'h000000, port_dir_d[dpm_pkg::PORT_B]} :
		(a_addr == dpm_pkg::OFS_P8_DATA) ? {24'h000000, port_data_d[dpm_pkg::PORT_8]} :
		(a_addr == dpm_pkg::OFS_P8_DIR) ? {24'h000000, port_dir_d[dpm_pkg::PORT_8]} :
		(a_addr == dpm_pkg::OFS_P9_DATA) ? {24'h000000, port_data_d[dpm_pkg::PORT_9]} :
		(a_addr == dpm_pkg::OFS_P9_DIR) ? {24'h000000, port_dir_d[dpm_pkg::PORT_9]} :
		(a_addr == dpm_pkg::OFS_PIN_LVL) ? pin_lvl :
		(a_addr == dpm_pkg::OFS_CORE_STAT) ? core_stat :
		32'h0000_0000;

	// Zero wait state, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
			hrdata_q <= dpm_pkg::HRDATA_RST;
		end else begin
			wr_pend_q <= a_write;
			wr_addr_q <= a_addr;
			if (a_read) begin
				hrdata_q <= rd_val;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			func_q <= dpm_pkg::FUNC_RST;
		end else begin
			func_q <= func_d;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < dpm_pkg::NPORT; i++) begin
				port_data_q[i] <= dpm_pkg::PORT_RST;
				port_dir_q[i] <= dpm_pkg::PORT_RST;
			end
		end else begin
			for (int i = 0; i < dpm_pkg::NPORT; i++) begin
				port_data_q[i] <= port_data_d[i];
				port_dir_q[i] <= port_dir_d[i];
			end
		end
	end

	// Pin input synchroniser
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= pin_i;
			sync2_q <= sync1_q;
		end
	end

	// Port bit that backs each pin; read strobe and first strobe pin have none
	assign prt_o[dpm_pkg::P_REQ] = port_data_q[dpm_pkg::PORT_B][3];
	assign prt_oe[dpm_pkg::P_REQ] = port_dir_q[dpm_pkg::PORT_B][3];
	assign prt_o[dpm_pkg::P_ACK] = port_data_q[dpm_pkg::PORT_B][4];
	assign prt_oe[dpm_pkg::P_ACK] = port_dir_q[dpm_pkg::PORT_B][4];
	assign prt_o[dpm_pkg::P_EOP] = port_data_q[dpm_pkg::PORT_B][5];
	assign prt_oe[dpm_pkg::P_EOP] = port_dir_q[dpm_pkg::PORT_B][5];
	assign prt_o[dpm_pkg::P_FBW] = port_data_q[dpm_pkg::PORT_B][6];
	assign prt_oe[dpm_pkg::P_FBW] = port_dir_q[dpm_pkg::PORT_B][6];
	assign prt_o[dpm_pkg::P_FBR] = port_data_q[dpm_pkg::PORT_B][7];
	assign prt_oe[dpm_pkg::P_FBR] = port_dir_q[dpm_pkg::PORT_B][7];
	assign prt_o[dpm_pkg::P_RDY] = port_data_q[dpm_pkg::PORT_8][0];
	assign prt_oe[dpm_pkg::P_RDY] = port_dir_q[dpm_pkg::PORT_8][0];
	assign prt_o[dpm_pkg::P_GNT] = port_data_q[dpm_pkg::PORT_8][1];
	assign prt_oe[dpm_pkg::P_GNT] = port_dir_q[dpm_pkg::PORT_8][1];
	assign prt_o[dpm_pkg::P_BRQ] = port_data_q[dpm_pkg::PORT_8][2];
	assign prt_oe[dpm_pkg::P_BRQ] = port_dir_q[dpm_pkg::PORT_8][2];
	assign prt_o[dpm_pkg::P_WRH] = 1'b0;
	assign prt_oe[dpm_pkg::P_WRH] = 1'b0;
	assign prt_o[dpm_pkg::P_WRL] = port_data_q[dpm_pkg::PORT_8][5];
	assign prt_oe[dpm_pkg::P_WRL] = port_dir_q[dpm_pkg::PORT_8][5];
	assign prt_o[dpm_pkg::P_WE] = port_data_q[dpm_pkg::PORT_9][7];
	assign prt_oe[dpm_pkg::P_WE] = port_dir_q[dpm_pkg::PORT_9][7];
	assign prt_o[dpm_pkg::P_RD] = 1'b0;
	assign prt_oe[dpm_pkg::P_RD] = 1'b0;

	// Request pin: input only while it is a start source, unless drive is wanted
	assign fn_sel[dpm_pkg::P_REQ] = req_src & ~req_drive;
	assign fn_o[dpm_pkg::P_REQ] = 1'b0;
	assign fn_oe[dpm_pkg::P_REQ] = 1'b0;

	assign fn_sel[dpm_pkg::P_ACK] = ack_en;
	assign fn_o[dpm_pkg::P_ACK] = dma1_ack_out;
	assign fn_oe[dpm_pkg::P_ACK] = 1'b1;

	// Shared pin drives only for end; stop alone leaves it an input
	assign fn_sel[dpm_pkg::P_EOP] = end_en | stop_en;
	assign fn_o[dpm_pkg::P_EOP] = dma1_transfer_end_out;
	assign fn_oe[dpm_pkg::P_EOP] = end_en;

	assign fn_sel[dpm_pkg::P_FBW] = fbw_en;
	assign fn_o[dpm_pkg::P_FBW] = flyby_write_strobe;
	assign fn_oe[dpm_pkg::P_FBW] = 1'b1;

	assign fn_sel[dpm_pkg::P_FBR] = fbr_en;
	assign fn_o[dpm_pkg::P_FBR] = flyby_read_strobe;
	assign fn_oe[dpm_pkg::P_FBR] = 1'b1;

	genvar gc;
	generate
		for (gc = 0; gc < 8; gc++) begin : g_cs
			assign fn_sel[dpm_pkg::P_CS0 + gc] = cs_en[gc];
			assign fn_o[dpm_pkg::P_CS0 + gc] = chip_select[gc];
			assign fn_oe[dpm_pkg::P_CS0 + gc] = 1'b1;
			assign prt_o[dpm_pkg::P_CS0 + gc] = port_data_q[dpm_pkg::PORT_A][gc];
			assign prt_oe[dpm_pkg::P_CS0 + gc] = port_dir_q[dpm_pkg::PORT_A][gc];
		end
	endgenerate

	assign fn_sel[dpm_pkg::P_RDY] = rdy_en;
	assign fn_o[dpm_pkg::P_RDY] = 1'b0;
	assign fn_oe[dpm_pkg::P_RDY] = 1'b0;

	assign fn_sel[dpm_pkg::P_GNT] = gnt_en;
	assign fn_o[dpm_pkg::P_GNT] = ~bus_released;
	assign fn_oe[dpm_pkg::P_GNT] = 1'b1;

	assign fn_sel[dpm_pkg::P_BRQ] = brq_en;
	assign fn_o[dpm_pkg::P_BRQ] = 1'b0;
	assign fn_oe[dpm_pkg::P_BRQ] = 1'b0;

	// First strobe pin has no port use; it swaps meaning in SRAM mode
	assign fn_sel[dpm_pkg::P_WRH] = 1'b1;
	assign fn_o[dpm_pkg::P_WRH] = sram_mode ? sram_high_byte_mask : write_strobe_high;
	assign fn_oe[dpm_pkg::P_WRH] = 1'b1;

	assign fn_sel[dpm_pkg::P_WRL] = wrl_en;
	assign fn_o[dpm_pkg::P_WRL] = sram_mode ? sram_low_byte_mask : write_strobe_low;
	assign fn_oe[dpm_pkg::P_WRL] = 1'b1;

	assign fn_sel[dpm_pkg::P_WE] = we_en;
	assign fn_o[dpm_pkg::P_WE] = sram_write_strobe;
	assign fn_oe[dpm_pkg::P_WE] = 1'b1;

	assign fn_sel[dpm_pkg::P_RD] = 1'b1;
	assign fn_o[dpm_pkg::P_RD] = read_strobe;
	assign fn_oe[dpm_pkg::P_RD] = 1'b1;

	// Final choice per pin
	assign pin_o_d = (fn_sel & fn_o) | (~fn_sel & prt_o);
	assign pin_oe_d = (fn_sel & fn_oe) | (~fn_sel & prt_oe);

	// Registered so a select change and a data change land on one edge
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_o_q <= '0;
			pin_oe_q <= '0;
		end else begin
			pin_o_q <= pin_o_d;
			pin_oe_q <= pin_oe_d;
		end
	end

	assign pin_o = pin_o_q;
	assign pin_oe = pin_oe_q;

	// Inputs towards the core; disabled inputs show their idle level
	assign req_d = req_src & sync2_q[dpm_pkg::P_REQ];
	assign stop_d = stop_en & sync2_q[dpm_pkg::P_EOP];
	assign rdy_d = ~rdy_en | sync2_q[dpm_pkg::P_RDY];
	assign brq_d = brq_en & sync2_q[dpm_pkg::P_BRQ];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			req_q <= 1'b0;
			stop_q <= 1'b0;
			rdy_q <= 1'b1;
			brq_q <= 1'b0;
		end else begin
			req_q <= req_d;
			stop_q <= stop_d;
			rdy_q <= rdy_d;
			brq_q <= brq_d;
		end
	end

	assign dma1_ext_request_in = req_q;
	assign dma1_transfer_stop_in = stop_q;
	assign ext_ready_in = rdy_q;
	assign bus_release_request_in = brq_q;

endmodule // dpm_pin_mux

// [verif/dpm_pin_mux_monitor.sv]
// Purpose: Port-level assertions for the pin multiplexer
// Assumes: Function word is written at offset 0x00 over AHB-Lite
// Notes: Shadows the function word from bus traffic, since it is not a port
`timescale 1ns/100ps

module dpm_pin_mux_monitor (
	// Clock, reset and bus
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	// Pins
	input wire logic [dpm_pkg::NPIN-1:0] pin_i,
	input wire logic [dpm_pkg::NPIN-1:0] pin_o,
	input wire logic [dpm_pkg::NPIN-1:0] pin_oe,
	// Core side
	input wire logic dma1_ack_out,
	input wire logic dma1_transfer_end_out,
	input wire logic flyby_write_strobe,
	input wire logic flyby_read_strobe,
	input wire logic [7:0] chip_select,
	input wire logic read_strobe,
	input wire logic sram_high_byte_mask,
	input wire logic bus_released,
	input wire logic dma1_ext_request_in,
	input wire logic dma1_transfer_stop_in,
	input wire logic ext_ready_in,
	input wire logic bus_release_request_in
);
	logic wr_q;
	logic [31:0] fn_q;
	logic [1:0] up_q;
	wire fn_sel = hsel && htrans[1] && hready && hwrite && haddr[7:0] == dpm_pkg::OFS_FUNC;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			fn_q <= dpm_pkg::FUNC_RST;
			up_q <= 2'd0;
		end else begin
			wr_q <= fn_sel;
			if (wr_q)
				fn_q <= hwdata;
			if (up_q != 2'd3)
				up_q <= up_q + 2'd1;
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// Address phase then data phase enabling chip select 0
	sequence s_cs0_write;
		fn_sel ##1 hwdata[dpm_pkg::FB_CS_LSB];
	endsequence
	// Pin synchronisers have filled since reset
	sequence s_synced;
		up_q == 2'd3;
	endsequence

	a_cs_enable_lands: assert property (s_cs0_write |-> ##2 pin_oe[5])
		else $error("chip select 0 not driven after enable");
	a_cs_follow_core: assert property (
		((pin_o[12:5] ^ $past(chip_select)) & $past(fn_q[23:16])) == 8'h00
		&& (pin_oe[12:5] & $past(fn_q[23:16])) == $past(fn_q[23:16]))
		else $error("enabled chip select pin wrong");
	a_ack_drive: assert property ($past(fn_q[0]) |->
		pin_oe[1] && pin_o[1] == $past(dma1_ack_out)) else $error("ack pin wrong");
	a_end_drive: assert property ($past(fn_q[1]) |->
		pin_oe[2] && pin_o[2] == $past(dma1_transfer_end_out)) else $error("end pin wrong");
	a_stop_gated: assert property (s_synced |->
		dma1_transfer_stop_in == ($past(pin_i[2], 3) && $past(fn_q[2])))
		else $error("stop input gating wrong");
	a_flyby_write: assert property ($past(fn_q[3]) |->
		pin_oe[3] && pin_o[3] == $past(flyby_write_strobe)) else $error("fly-by write pin wrong");
	a_flyby_read: assert property ($past(fn_q[4]) |->
		pin_oe[4] && pin_o[4] == $past(flyby_read_strobe)) else $error("fly-by read pin wrong");
	a_ready_gated: assert property (s_synced |->
		ext_ready_in == (!$past(fn_q[5]) || $past(pin_i[13], 3)))
		else $error("ready input gating wrong");
	a_grant_low: assert property ($past(fn_q[6]) |->
		pin_oe[14] && pin_o[14] == !$past(bus_released)) else $error("grant pin wrong");
	a_brq_gated: assert property (s_synced |->
		bus_release_request_in == ($past(pin_i[15], 3) && $past(fn_q[7])))
		else $error("bus request gating wrong");
	a_req_released: assert property ($past(fn_q[11]) && !$past(fn_q[12]) |-> !pin_oe[0])
		else $error("request pin driven while sampled");
	a_req_sampled: assert property (s_synced |->
		dma1_ext_request_in == ($past(pin_i[0], 3) && $past(fn_q[11])))
		else $error("request input gating wrong");
	a_read_strobe: assert property (up_q != 2'd0 |->
		pin_oe[19] && pin_o[19] == $past(read_strobe)) else $error("read strobe pin wrong");
	a_sram_high_mask: assert property ($past(fn_q[10]) && up_q != 2'd0 |->
		pin_o[16] == $past(sram_high_byte_mask)) else $error("high mask pin wrong");
endmodule // dpm_pin_mux_monitor

bind dpm_pin_mux dpm_pin_mux_monitor mon_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
	.pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe), .dma1_ack_out(dma1_ack_out),
	.dma1_transfer_end_out(dma1_transfer_end_out), .flyby_write_strobe(flyby_write_strobe),
	.flyby_read_strobe(flyby_read_strobe), .ext_ready_in(ext_ready_in),
	.chip_select(chip_select), .read_strobe(read_strobe),
	.sram_high_byte_mask(sram_high_byte_mask), .bus_released(bus_released),
	.dma1_ext_request_in(dma1_ext_request_in), .dma1_transfer_stop_in(dma1_transfer_stop_in),
	.bus_release_request_in(bus_release_request_in));

// [verif/dpm_ext_model.sv]
// Purpose: External memories and masters on the multiplexed pins
// Assumes: A pin the block drives reads back its own level
// Notes: A pin nobody drives toggles every cycle, so it never holds a value
`timescale 1ns/100ps

module dpm_ext_model (
	// Clock
	input wire logic hclk,
	// Pin side of the block
	input wire logic [19:0] pin_o,
	input wire logic [19:0] pin_oe,
	output logic [19:0] pin_i,
	// Levels driven by the external devices
	input wire logic [19:0] ext_drv,
	input wire logic [19:0] ext_en
);
	logic tog_q = 1'b0;

	always_ff @(posedge hclk)
		tog_q <= ~tog_q;

	// Devices drive any pin only where the block has let go
	assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_en & ext_drv)
		| (~pin_oe & ~ext_en & {20{tog_q}});
endmodule // dpm_ext_model

// [verif/dpm_pin_mux_bench.sv]
// Purpose: Self-checking bench for the pin multiplexer
// Assumes: Zero-wait AHB-Lite slave; pin levels read back at offset 0x24
// Notes: Random function words, port settings, core and external levels
`timescale 1ns/100ps

module dpm_pin_mux_bench;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic rd_ph = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, rnd = 32'h33, fn = 32'h0;
	logic [18:0] core = 19'h0;
	logic [19:0] xv = 20'h0, lvl;
	logic [7:0] pd [4] = '{default: 8'h00};
	logic [7:0] pr [4] = '{default: 8'h00};
	logic [31:0] exq [$];
	wire hready;
	wire hresp;
	wire [31:0] hrdata;
	wire [19:0] pin_i, pin_o, pin_oe;
	int err_count = 0;
	int check_count = 0;

	always #2 hclk = ~hclk;

	dpm_pin_mux dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .pin_i(pin_i), .pin_o(pin_o),
		.pin_oe(pin_oe), .dma1_ack_out(core[0]), .dma1_transfer_end_out(core[1]),
		.flyby_write_strobe(core[2]), .flyby_read_strobe(core[3]), .chip_select(core[11:4]),
		.read_strobe(core[12]), .write_strobe_high(core[13]), .write_strobe_low(core[14]),
		.sram_high_byte_mask(core[15]), .sram_low_byte_mask(core[16]),
		.sram_write_strobe(core[17]), .bus_released(core[18]), .dma1_ext_request_in(),
		.dma1_transfer_stop_in(), .ext_ready_in(), .bus_release_request_in());

	dpm_ext_model ext_u (.hclk(hclk), .pin_o(pin_o), .pin_oe(pin_oe), .pin_i(pin_i),
		.ext_drv(xv), .ext_en(20'hfffff));

	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		return v ^ (v << 5);
	endfunction

	// Expected synced level of every pin
	function automatic logic [19:0] exp_lvl();
		logic [19:0] oe;
		logic [19:0] o;
		oe = {1'b1, fn[9] | pr[3][7], fn[8] | pr[2][5], 1'b1, ~fn[7] & pr[2][2], fn[6] | pr[2][1],
			~fn[5] & pr[2][0], fn[23:16] | pr[0], fn[4] | pr[1][7], fn[3] | pr[1][6],
			fn[1] | (~fn[2] & pr[1][5]), fn[0] | pr[1][4], ~(fn[11] & ~fn[12]) & pr[1][3]};
		o = {core[12], fn[9] ? core[17] : pd[3][7], fn[8] ? (fn[10] ? core[16] : core[14]) :
			pd[2][5], fn[10] ? core[15] : core[13], pd[2][2], fn[6] ? ~core[18] : pd[2][1],
			pd[2][0], (core[11:4] & fn[23:16]) | (pd[0] & ~fn[23:16]), fn[4] ? core[3] : pd[1][7],
			fn[3] ? core[2] : pd[1][6], fn[1] ? core[1] : pd[1][5], fn[0] ? core[0] : pd[1][4],
			pd[1][3]};
		return (oe & o) | (~oe & xv);
	endfunction

	task automatic stop_test();
		$display("Checks %0d, mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wait_rdy();
		int n;
		n = 0;
		@(posedge hclk);
		while (hready !== 1'b1) begin
			n++;
			if (n > 100) begin
				err_count++;
				stop_test();
			end
			@(posedge hclk);
		end
	endtask

	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= wr;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= wd;
		rd_ph <= ~wr;
		wait_rdy();
		rd_ph <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exq.push_back(e);
		ahb(1'b0, a, 32'h0);
	endtask

	// Read data is taken at the edge that ends the data phase
	always @(posedge hclk) begin
		if (rd_ph && hready) begin
			check("hrdata", hrdata, exq.pop_front());
			check("hresp", {31'h0, hresp}, 32'h0);
		end
	end

	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		rd(dpm_pkg::OFS_FUNC, dpm_pkg::FUNC_RST);
		rd(dpm_pkg::OFS_CORE_STAT, 32'h4);
		ahb(1'b1, 8'h80, 32'hffff_ffff);
		rd(8'h80, 32'h0);
		for (int i = 0; i < 40; i++) begin
			for (int p = 0; p < 4; p++) begin
				rnd = xs(rnd);
				pd[p] = rnd[7:0];
				pr[p] = rnd[15:8];
				ahb(1'b1, dpm_pkg::OFS_PA_DATA + 8'(8 * p), rnd);
				ahb(1'b1, dpm_pkg::OFS_PA_DIR + 8'(8 * p), rnd >> 8);
				rd(dpm_pkg::OFS_PA_DIR + 8'(8 * p), {24'h0, pr[p]});
			end
			rnd = xs(rnd);
			fn = (i == 0) ? 32'h0 : (i == 1) ? 32'h00ff_1fff : rnd & 32'h00ff_1fff;
			rnd = xs(rnd);
			core <= rnd[18:0];
			xv <= rnd[31:12];
			ahb(1'b1, dpm_pkg::OFS_FUNC, fn);
			rd(dpm_pkg::OFS_FUNC, fn);
			// Output flop, two sync flops and the level register
			repeat (4) @(posedge hclk);
			lvl = exp_lvl();
			rd(dpm_pkg::OFS_PIN_LVL, {12'h0, lvl});
			rd(dpm_pkg::OFS_CORE_STAT, {28'h0, lvl[15] & fn[7], fn[5] ? lvl[13] : 1'b1,
				lvl[2] & fn[2], lvl[0] & fn[11]});
		end
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		rd(dpm_pkg::OFS_FUNC, dpm_pkg::FUNC_RST);
		@(posedge hclk);
		stop_test();
	end
endmodule // dpm_pin_mux_bench
